// file: hw/ssph_pkg.sv
// Package holding primitive codes, timing counts and states for the primitive handler.
package ssph_pkg;
    localparam int CLK_HZ        = 20000000;
    localparam int PLE_LIMIT_US  = 1000;
    localparam int PLE_LIMIT_CYC = (PLE_LIMIT_US * (CLK_HZ / 1000000));
    localparam int NOTIFY_GAP    = 3;
    localparam int ENCL_TYPE_W   = 5;
    localparam logic [4:0] ENCL_DEV_TYPE = 5'h0D;

    // Received primitive codes presented by the dword decoder.
    typedef enum logic [4:0] {
        SSPH_P_NONE      = 5'h00,
        SSPH_P_BC_CHANGE = 5'h01,
        SSPH_P_BC_RSVCH0 = 5'h02,
        SSPH_P_BC_RSVCH1 = 5'h03,
        SSPH_P_BC_SES    = 5'h04,
        SSPH_P_BC_EXP    = 5'h05,
        SSPH_P_BC_RSV2   = 5'h06,
        SSPH_P_BC_RSV3   = 5'h07,
        SSPH_P_BC_RSV4   = 5'h08,
        SSPH_P_CL_NORMAL = 5'h09,
        SSPH_P_CL_CLRAFF = 5'h0A,
        SSPH_P_CL_RSV0   = 5'h0B,
        SSPH_P_CL_RSV1   = 5'h0C,
        SSPH_P_HRESET    = 5'h0D,
        SSPH_P_NT_SPINUP = 5'h0E,
        SSPH_P_NT_PLE    = 5'h0F,
        SSPH_P_NT_RSV0   = 5'h10,
        SSPH_P_NT_RSV1   = 5'h11,
        SSPH_P_NT_RSV2   = 5'h12,
        SSPH_P_ALIGN     = 5'h13
    } ssph_prim_t;

    // Fill choices for a slot that would otherwise carry a clock-skew ALIGN.
    typedef enum logic [1:0] {
        SSPH_F_ALIGN  = 2'b00,
        SSPH_F_SPINUP = 2'b01,
        SSPH_F_PLE    = 2'b10
    } ssph_fill_t;

    // Power loss handling states.
    typedef enum logic [1:0] {
        SSPH_S_IDLE  = 2'b00,
        SSPH_S_ARMED = 2'b01,
        SSPH_S_DONE  = 2'b10
    } ssph_plstate_t;
endpackage

// file: hw/ssph_primitive_handler.sv
// Link-layer handler for connection-independent primitives of a target phy.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: Before link reset completes, no BROADCAST is sent and received ones are ignored.
// RULE2: Inside a connection no BROADCAST is sent and received ones are ignored.
// RULE3: Both reserved-change BROADCASTs are reported as a configuration change.
// RULE4: The enclosure-services BROADCAST reports an event from device type 0Dh.
// RULE5: Expander-event BROADCAST reports detector threshold or clear, never domain change.
// RULE6: Clear-affiliation CLOSE clears an STP affiliation, otherwise acts as normal CLOSE.
// RULE7: Reserved CLOSE variants close the connection like a normal CLOSE.
// RULE8: Expanders replace forwarded invalid dwords with ERROR.
// RULE9: HARD_RESET acts only after phy reset with no identification since.
// RULE10: NOTIFY may fill an ALIGN slot, taking a rotation step or delaying it.
// RULE11: At least three ALIGNs or other NOTIFYs before repeating one NOTIFY.
// RULE12: Expanders send ALIGN in place of NOTIFY instead of forwarding it.
// RULE13: The far side sends spin-up permission after power on, then periodically.
// RULE14: Resets and nexus loss do not make a later spin-up permission start spin-up; only lunSpinReset and hardResetEvt clear it, no nexus loss input.
// RULE15: Spin-up permission from either port is accepted alike, spin-up as configured.
// RULE16: Reserved NOTIFY variants are ignored with no side effect.
// RULE17: The far side sends power-loss-expected at least three times.
// RULE18: Within 1 ms of power-loss-expected: stop writes, clear tasks, raise attention; write stop waits for blockBoundary until timer expiry.
// RULE19: After power-loss-expected, BREAK any open SSP connection.
// RULE20: After power-loss-expected, reject SSP opens with retry until the timer expires.
// RULE21: Frames arriving after power-loss-expected before the connection closes are dropped.
// RULE22: Power loss timer is loaded and stopped at power on, started by power-loss-expected; reset clears it to zero and the notice loads plTimeout.
// RULE23: On timer expiry raise power-fail attention and accept SSP opens again.
// RULE24: Timer length comes from a config input; expiry is a one-cycle pulse.
module ssph_primitive_handler #(
    parameter int TIMER_W = 24
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic [4:0]          rxPrim0,
    input  wire logic                rxValid0,
    input  wire logic [4:0]          rxPrim1,
    input  wire logic                rxValid1,
    input  wire logic [4:0]          sesDevType,
    input  wire logic                linkResetDone,
    input  wire logic                phyResetDone,
    input  wire logic                identDone,
    input  wire logic                connOpen,
    input  wire logic                connIsStp,
    input  wire logic                stpAffPresent,
    input  wire logic                sspConn,
    input  wire logic                openReq,
    input  wire logic                frameIn,
    input  wire logic                alignSlot,
    input  wire logic                spinupArmed,
    input  wire logic                lunSpinReset,
    input  wire logic                bcastReq,
    input  wire logic                blockBoundary,
    input  wire logic [TIMER_W-1:0]  plTimeout,
    output logic                     bcastChangeEvt,
    output logic                     bcastSesEvt,
    output logic                     bcastExpEvt,
    output logic                     bcastTx,
    output logic                     closeEvt,
    output logic                     clearAffEvt,
    output logic                     hardResetEvt,
    output logic [1:0]               slotFill,
    output logic                     spinupGo,
    output logic                     writeStop,
    output logic                     taskClear,
    output logic                     uaPowerLoss,
    output logic                     uaPowerFail,
    output logic                     breakTx,
    output logic                     openRejectRetry,
    output logic                     frameDrop,
    output logic                     plTimerExpired
);
    if (TIMER_W < 2 || TIMER_W > 32) begin
        $error("TIMER_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic rxP0;
    logic rxP1;
    assign rxP0 = rxValid0;
    assign rxP1 = rxValid1;

    function automatic logic isPrim(input logic                 v,
                                    input logic [4:0]           p,
                                    input ssph_pkg::ssph_prim_t c);
        return v && (p == c);
    endfunction

    // Reception on either port counts equally.
    function automatic logic anyPrim(input ssph_pkg::ssph_prim_t c);
        return isPrim(rxP0, rxPrim0, c) || isPrim(rxP1, rxPrim1, c);
    endfunction

    logic bcastOk;
    assign bcastOk = linkResetDone && !connOpen; // [RULE1] [RULE2]

    ////////////////////////////////////////////////////////////////////////////////
    // BROADCAST reception and transmission.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bcastChangeEvt <= 1'b0;
            bcastSesEvt    <= 1'b0;
            bcastExpEvt    <= 1'b0;
            bcastTx        <= 1'b0;
        end else begin
            bcastChangeEvt <= bcastOk && (anyPrim(ssph_pkg::SSPH_P_BC_CHANGE)
                              || anyPrim(ssph_pkg::SSPH_P_BC_RSVCH0)
                              || anyPrim(ssph_pkg::SSPH_P_BC_RSVCH1)); // [RULE3]
            bcastSesEvt    <= bcastOk && anyPrim(ssph_pkg::SSPH_P_BC_SES)
                              && (sesDevType == ssph_pkg::ENCL_DEV_TYPE); // [RULE4]
            bcastExpEvt    <= bcastOk && anyPrim(ssph_pkg::SSPH_P_BC_EXP); // [RULE5]
            bcastTx        <= bcastOk && bcastReq; // [RULE1] [RULE2]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // CLOSE handling.
    logic anyClose;
    assign anyClose = anyPrim(ssph_pkg::SSPH_P_CL_NORMAL) || anyPrim(ssph_pkg::SSPH_P_CL_CLRAFF)
                   || anyPrim(ssph_pkg::SSPH_P_CL_RSV0) || anyPrim(ssph_pkg::SSPH_P_CL_RSV1);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            closeEvt    <= 1'b0;
            clearAffEvt <= 1'b0;
        end else begin
            closeEvt    <= connOpen && anyClose; // [RULE7]
            clearAffEvt <= connOpen && anyPrim(ssph_pkg::SSPH_P_CL_CLRAFF)
                           && connIsStp && stpAffPresent; // [RULE6]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // HARD_RESET validity window: opens at phy reset done, closes on identification.
    logic hrWin_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hrWin_q <= 1'b0;
        end else if (phyResetDone) begin
            hrWin_q <= 1'b1; // [RULE9]
        end else if (identDone) begin
            hrWin_q <= 1'b0; // [RULE9]
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hardResetEvt <= 1'b0;
        end else begin
            hardResetEvt <= hrWin_q && anyPrim(ssph_pkg::SSPH_P_HRESET); // [RULE9]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // NOTIFY transmission into ALIGN slots. Spacing counters count slots since each
    // variant was last sent, saturating at NOTIFY_GAP.
    logic [1:0] gapSpin_q;
    logic [1:0] gapPle_q;
    logic       spinReq_q;
    logic       pleTxReq;
    logic [1:0] fill_d;

    always_comb begin
        fill_d = ssph_pkg::SSPH_F_ALIGN;
        if (alignSlot) begin
            if (pleTxReq && gapPle_q == 2'(ssph_pkg::NOTIFY_GAP)) begin
                fill_d = ssph_pkg::SSPH_F_PLE; // [RULE10] [RULE11]
            end else if (spinReq_q && gapSpin_q == 2'(ssph_pkg::NOTIFY_GAP)) begin
                fill_d = ssph_pkg::SSPH_F_SPINUP; // [RULE10] [RULE11]
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gapSpin_q <= 2'(ssph_pkg::NOTIFY_GAP);
            gapPle_q  <= 2'(ssph_pkg::NOTIFY_GAP);
            slotFill  <= ssph_pkg::SSPH_F_ALIGN;
        end else begin
            slotFill <= fill_d;
            if (alignSlot) begin
                gapSpin_q <= (fill_d == ssph_pkg::SSPH_F_SPINUP) ? 2'h0
                           : (gapSpin_q == 2'(ssph_pkg::NOTIFY_GAP) ? gapSpin_q : gapSpin_q + 2'h1);
                gapPle_q  <= (fill_d == ssph_pkg::SSPH_F_PLE) ? 2'h0
                           : (gapPle_q == 2'(ssph_pkg::NOTIFY_GAP) ? gapPle_q : gapPle_q + 2'h1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Spin-up permission. A reset clears the armed request so permission alone
    // never starts the spindle; the set of a new request wins over the clear.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            spinReq_q <= 1'b0;
        end else if (spinupArmed) begin
            spinReq_q <= 1'b1;
        end else if (lunSpinReset || hardResetEvt) begin
            spinReq_q <= 1'b0; // [RULE14]
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            spinupGo <= 1'b0;
        end else begin
            spinupGo <= spinReq_q && anyPrim(ssph_pkg::SSPH_P_NT_SPINUP); // [RULE15] [RULE16]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power loss handling and timer.
    ssph_pkg::ssph_plstate_t plState_q;
    logic [TIMER_W-1:0]      plTimer_q;
    logic                    pleRx;
    logic                    plActive;
    logic                    expire;

    assign pleRx    = anyPrim(ssph_pkg::SSPH_P_NT_PLE);
    assign plActive = (plState_q == ssph_pkg::SSPH_S_ARMED);
    assign expire   = plActive && (plTimer_q == '0);
    assign pleTxReq = 1'b0;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            plState_q <= ssph_pkg::SSPH_S_IDLE;
        end else begin
            unique case (plState_q)
                ssph_pkg::SSPH_S_IDLE:  if (pleRx) plState_q <= ssph_pkg::SSPH_S_ARMED; // [RULE22]
                ssph_pkg::SSPH_S_ARMED: if (expire) plState_q <= ssph_pkg::SSPH_S_DONE;
                ssph_pkg::SSPH_S_DONE:  if (pleRx) plState_q <= ssph_pkg::SSPH_S_ARMED;
                default:                plState_q <= ssph_pkg::SSPH_S_IDLE;
            endcase
        end
    end

    // Repeated notices while armed do not restart the count, so the window stays bounded.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            plTimer_q <= '0; // [RULE22]
        end else if (pleRx && !plActive) begin
            plTimer_q <= plTimeout; // [RULE24]
        end else if (plActive && plTimer_q != '0) begin
            plTimer_q <= plTimer_q - 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            plTimerExpired <= 1'b0;
            uaPowerFail    <= 1'b0;
        end else begin
            plTimerExpired <= expire; // [RULE24]
            uaPowerFail    <= expire; // [RULE23]
        end
    end

    // Write stop waits for a block boundary; the notice pulses go out on the next edge.
    logic wsPend_q;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wsPend_q    <= 1'b0;
            writeStop   <= 1'b0;
            taskClear   <= 1'b0;
            uaPowerLoss <= 1'b0;
        end else begin
            taskClear   <= pleRx && !plActive; // [RULE18]
            uaPowerLoss <= pleRx && !plActive; // [RULE18]
            if (pleRx && !plActive) begin
                wsPend_q <= 1'b1;
            end else if (expire) begin
                wsPend_q  <= 1'b0;
                writeStop <= 1'b0;
            end
            if (wsPend_q && blockBoundary && !expire) begin
                writeStop <= 1'b1; // [RULE18]
            end
        end
    end

    // Connection-side actions while the notice is in force.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            breakTx         <= 1'b0;
            openRejectRetry <= 1'b0;
            frameDrop       <= 1'b0;
        end else begin
            breakTx         <= pleRx && connOpen && sspConn && !plActive; // [RULE19]
            openRejectRetry <= plActive && !expire && openReq; // [RULE20] [RULE23]
            frameDrop       <= plActive && connOpen && frameIn; // [RULE21]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_bc_gate: assert property (@(posedge mclk) disable iff (rst) // [RULE2]
        (!linkResetDone || connOpen) |=> !bcastChangeEvt && !bcastTx)
        else $error("broadcast passed while gated");
    a_ses_type: assert property (@(posedge mclk) disable iff (rst) // [RULE4]
        bcastSesEvt |-> $past(sesDevType) == ssph_pkg::ENCL_DEV_TYPE)
        else $error("ses event from wrong type");
    a_hr_window: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
        hardResetEvt |-> $past(hrWin_q))
        else $error("hard reset outside window");
    a_clraff_stp: assert property (@(posedge mclk) disable iff (rst) // [RULE6]
        clearAffEvt |-> closeEvt && $past(connIsStp))
        else $error("affiliation cleared without close");
    a_spin_gap: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
        (slotFill == ssph_pkg::SSPH_F_SPINUP) |=> (slotFill != ssph_pkg::SSPH_F_SPINUP))
        else $error("spinup notify repeated");
    a_spin_reset: assert property (@(posedge mclk) disable iff (rst) // [RULE14]
        (lunSpinReset && !spinupArmed) |=> ##1 !spinupGo)
        else $error("spinup after reset");
    sequence s_ple_seen;
        pleRx && !plActive;
    endsequence
    a_ple_notice: assert property (@(posedge mclk) disable iff (rst) // [RULE18]
        s_ple_seen |=> taskClear && uaPowerLoss)
        else $error("power loss notice missing");
    a_ple_reject: assert property (@(posedge mclk) disable iff (rst) // [RULE20]
        (plActive && !expire && openReq) |=> openRejectRetry)
        else $error("open not rejected");
    a_tmr_stopped: assert property (@(posedge mclk) disable iff (rst) // [RULE22]
        (plState_q == ssph_pkg::SSPH_S_IDLE) |-> plTimer_q == '0)
        else $error("timer ran before notice");
    a_expire_pulse: assert property (@(posedge mclk) disable iff (rst) // [RULE24]
        plTimerExpired |=> !plTimerExpired)
        else $error("expiry not single cycle");
    a_hr_ident: assert property (@(posedge mclk) disable iff (rst) // [RULE9]
        (identDone && !phyResetDone) |=> ##1 !hardResetEvt)
        else $error("hard reset after identification");
    a_ws_boundary: assert property (@(posedge mclk) disable iff (rst) // [RULE18]
        $rose(writeStop) |-> $past(blockBoundary) && $past(wsPend_q))
        else $error("write stopped off a block boundary");
    a_brk_ssp: assert property (@(posedge mclk) disable iff (rst) // [RULE19]
        breakTx |-> $past(sspConn) && $past(connOpen) && $past(pleRx))
        else $error("break without open ssp connection");
    a_drop_active: assert property (@(posedge mclk) disable iff (rst) // [RULE21]
        frameDrop |-> $past(plActive))
        else $error("frame dropped outside notice");
    a_accept_again: assert property (@(posedge mclk) disable iff (rst) // [RULE23]
        (plState_q == ssph_pkg::SSPH_S_DONE) |-> !openRejectRetry && !writeStop)
        else $error("open still rejected after expiry");
endmodule

// file: bench/ssph_far_port.sv
// Behavioural far-side port model that sends primitives on both receive lanes.
`timescale 1ns/1ps
module ssph_far_port (
    input  wire logic       mclk,
    output logic      [4:0] rxPrim0,
    output logic            rxValid0,
    output logic      [4:0] rxPrim1,
    output logic            rxValid1
);
    initial begin
        rxPrim0  = 5'h1F;
        rxValid0 = 1'b0;
        rxPrim1  = 5'h1E;
        rxValid1 = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One dword per call; a released lane shows the inverted code so a stale value never passes.
    task automatic sendPrim(input int port, input logic [4:0] code);
        @(negedge mclk);
        rxPrim0  = (port == 0) ? code : rxPrim0;
        rxValid0 = (port == 0) ? 1'b1 : rxValid0;
        rxPrim1  = (port != 0) ? code : rxPrim1;
        rxValid1 = (port != 0) ? 1'b1 : rxValid1;
        @(negedge mclk);
        rxPrim0  = ~rxPrim0;
        rxValid0 = 1'b0;
        rxPrim1  = ~rxPrim1;
        rxValid1 = 1'b0;
    endtask

    // Power loss warning goes out three times, with ALIGN dwords filling the gap between copies.
    task automatic sendPowerLoss(input int port);
        for (int i = 0; i < 3; i++) begin
            sendPrim(port, ssph_pkg::SSPH_P_NT_PLE);
            for (int k = 0; k < ssph_pkg::NOTIFY_GAP; k++) begin
                sendPrim(port, ssph_pkg::SSPH_P_ALIGN);
            end
        end
    endtask
endmodule

// file: bench/ssph_primitive_handler_tb_top.sv
// Self-checking testbench for the primitive handler.
`timescale 1ns/1ps
module ssph_primitive_handler_tb_top;
    localparam int TMO = 40;
    localparam logic [14:0] E_CHG = 15'h4000, E_SES = 15'h2000, E_EXP = 15'h1000,
        E_BTX = 15'h0800, E_CLS = 15'h0400, E_AFF = 15'h0200, E_HRS = 15'h0100,
        E_SPN = 15'h0080, E_TSK = 15'h0040, E_UAL = 15'h0020, E_UAF = 15'h0010,
        E_BRK = 15'h0008, E_REJ = 15'h0004, E_DRP = 15'h0002, E_TEX = 15'h0001;

    logic        mclk = 1'b0;
    logic        rst;
    logic [4:0]  rxPrim0, rxPrim1, sesDevType;
    logic        rxValid0, rxValid1, linkResetDone, phyResetDone, identDone, connOpen;
    logic        connIsStp, stpAffPresent, sspConn, openReq, frameIn, alignSlot;
    logic        spinupArmed, lunSpinReset, bcastReq, blockBoundary;
    logic [23:0] plTimeout;
    logic        bcastChangeEvt, bcastSesEvt, bcastExpEvt, bcastTx, closeEvt, clearAffEvt;
    logic        hardResetEvt, spinupGo, writeStop, taskClear, uaPowerLoss, uaPowerFail;
    logic        breakTx, openRejectRetry, frameDrop, plTimerExpired, slotQ;
    logic [1:0]  slotFill;
    logic [14:0] evts;
    logic [14:0] expQ[$];
    int          n_fail = 0, total_checks = 0, cyc = 0, t0 = 0, texCyc = 0;
    int          sinceFill = 3, nFill = 0;

    assign evts = {bcastChangeEvt, bcastSesEvt, bcastExpEvt, bcastTx, closeEvt, clearAffEvt,
        hardResetEvt, spinupGo, taskClear, uaPowerLoss, uaPowerFail, breakTx,
        openRejectRetry, frameDrop, plTimerExpired};

    ssph_primitive_handler u_dut (.mclk, .rst, .rxPrim0, .rxValid0, .rxPrim1, .rxValid1,
        .sesDevType, .linkResetDone, .phyResetDone, .identDone, .connOpen, .connIsStp,
        .stpAffPresent, .sspConn, .openReq, .frameIn, .alignSlot, .spinupArmed,
        .lunSpinReset, .bcastReq, .blockBoundary, .plTimeout, .bcastChangeEvt,
        .bcastSesEvt, .bcastExpEvt, .bcastTx, .closeEvt, .clearAffEvt, .hardResetEvt,
        .slotFill, .spinupGo, .writeStop, .taskClear, .uaPowerLoss, .uaPowerFail, .breakTx,
        .openRejectRetry, .frameDrop, .plTimerExpired);
    ssph_far_port u_far (.mclk, .rxPrim0, .rxValid0, .rxPrim1, .rxValid1);

    always #25 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic note(input string msg);
        n_fail++;
        $display("wrong value at %0t: %s", $time, msg);
    endtask

    task automatic checkBit(input logic got, input logic exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            note(msg);
        end
    endtask

    task automatic checkEvt(input logic [14:0] exp, input logic [14:0] got);
        total_checks++;
        if (got !== exp) begin
            note($sformatf("pulses %h, expected %h", got, exp));
        end
    endtask

    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask

    // A missing pulse only shows as an entry left in the queue, so the queue is checked and drained per test.
    task automatic settle();
        repeat (4) @(negedge mclk);
        checkBit(expQ.size() == 0, 1'b1, "expected pulse missing");
        expQ.delete();
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        slotQ <= alignSlot;
        if (cyc == 5000) begin
            note("run did not finish in time");
            tally_and_finish();
        end
    end

    // Outputs are registered, so the falling edge sees them settled.
    always @(negedge mclk) begin
        if (!rst && evts !== 15'h0000) begin
            if (expQ.size() == 0) begin
                note("pulse with nothing pending");
            end else begin
                checkEvt(expQ.pop_front(), evts);
            end
            if (evts[0] === 1'b1) begin
                texCyc = cyc;
            end
        end
        if (!rst && slotQ === 1'b1) begin
            if (slotFill !== 2'h0) begin
                checkBit(slotFill === 2'h1 && sinceFill >= 3, 1'b1, "notify fill");
                sinceFill = 0;
                nFill++;
            end else begin
                sinceFill++;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(22));
        rst = 1'b1;
        sesDevType = 5'h00;
        plTimeout = 24'(TMO);
        {linkResetDone, phyResetDone, identDone, connOpen, connIsStp, stpAffPresent} = '0;
        {sspConn, openReq, frameIn, alignSlot, spinupArmed, lunSpinReset} = '0;
        {bcastReq, blockBoundary} = '0;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        u_far.sendPrim(0, ssph_pkg::SSPH_P_BC_CHANGE);
        pulse(bcastReq);
        linkResetDone = 1'b1;
        connOpen = 1'b1;
        u_far.sendPrim(1, ssph_pkg::SSPH_P_BC_CHANGE);
        pulse(bcastReq);
        settle();
        $display("test broadcast refusal done");
        connOpen = 1'b0;
        for (int i = 1; i <= 3; i++) begin
            expQ.push_back(E_CHG);
            u_far.sendPrim(int'($urandom % 2), 5'(i));
        end
        sesDevType = 5'h0D ^ 5'(1 + $urandom % 31);
        u_far.sendPrim(0, ssph_pkg::SSPH_P_BC_SES);
        sesDevType = ssph_pkg::ENCL_DEV_TYPE;
        expQ.push_back(E_SES);
        u_far.sendPrim(1, ssph_pkg::SSPH_P_BC_SES);
        expQ.push_back(E_EXP);
        u_far.sendPrim(0, ssph_pkg::SSPH_P_BC_EXP);
        expQ.push_back(E_BTX);
        pulse(bcastReq);
        settle();
        $display("test broadcast codes done");
        connOpen = 1'b1;
        for (int i = 9; i <= 12; i++) begin
            expQ.push_back(E_CLS);
            u_far.sendPrim(int'($urandom % 2), 5'(i));
        end
        connIsStp = 1'b1;
        stpAffPresent = 1'b1;
        expQ.push_back(E_CLS | E_AFF);
        u_far.sendPrim(0, ssph_pkg::SSPH_P_CL_CLRAFF);
        stpAffPresent = 1'b0;
        expQ.push_back(E_CLS);
        u_far.sendPrim(1, ssph_pkg::SSPH_P_CL_CLRAFF);
        settle();
        $display("test close codes done");
        {connOpen, connIsStp} = 2'b00;
        u_far.sendPrim(0, ssph_pkg::SSPH_P_HRESET);
        pulse(phyResetDone);
        expQ.push_back(E_HRS);
        u_far.sendPrim(1, ssph_pkg::SSPH_P_HRESET);
        pulse(identDone);
        u_far.sendPrim(0, ssph_pkg::SSPH_P_HRESET);
        settle();
        $display("test hard reset window done");
        pulse(spinupArmed);
        alignSlot = 1'b1;
        repeat (12) @(negedge mclk);
        alignSlot = 1'b0;
        @(negedge mclk);
        checkBit(nFill > 0, 1'b1, "no notify in align slots");
        pulse(spinupArmed);
        for (int i = 16; i <= 18; i++) begin
            u_far.sendPrim(int'($urandom % 2), 5'(i));
        end
        expQ.push_back(E_SPN);
        u_far.sendPrim(1, ssph_pkg::SSPH_P_NT_SPINUP);
        pulse(spinupArmed);
        expQ.push_back(E_SPN);
        u_far.sendPrim(0, ssph_pkg::SSPH_P_NT_SPINUP);
        pulse(spinupArmed);
        pulse(lunSpinReset);
        u_far.sendPrim(1, ssph_pkg::SSPH_P_NT_SPINUP);
        pulse(phyResetDone);
        pulse(spinupArmed);
        expQ.push_back(E_HRS);
        u_far.sendPrim(0, ssph_pkg::SSPH_P_HRESET);
        u_far.sendPrim(0, ssph_pkg::SSPH_P_NT_SPINUP);
        settle();
        $display("test spin-up permission done");
        {connOpen, sspConn} = 2'b11;
        t0 = cyc;
        expQ.push_back(E_BRK | E_TSK | E_UAL);
        fork
            u_far.sendPowerLoss(int'($urandom % 2));
            begin
                repeat (3) @(negedge mclk);
                expQ.push_back(E_DRP);
                pulse(frameIn);
                expQ.push_back(E_REJ);
                pulse(openReq);
                checkBit(writeStop, 1'b0, "write stopped before boundary");
                pulse(blockBoundary);
                checkBit(writeStop, 1'b1, "write not stopped");
            end
        join
        expQ.push_back(E_UAF | E_TEX);
        repeat (TMO) @(negedge mclk);
        checkBit(texCyc - t0 inside {[TMO + 2:TMO + 5]}, 1'b1, "expiry time");
        checkBit(writeStop, 1'b0, "write stop held past expiry");
        pulse(openReq);
        settle();
        $display("test power loss done");
        tally_and_finish();
    end
endmodule
